// *** return_rotate_nop_exec.v ***
// Execute logic for no-operation, the three returns and rotate-left-through-carry.
// Assumes the fetch unit presents one instruction with instr_valid and waits on busy.
`timescale 1ns/1ps
`default_nettype none
`include "rret_consts.vh"
module return_rotate_nop_exec #(
  parameter STACK_DEPTH = 8,
  parameter STACK_AW    = 3
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        instr_valid,
  input  wire [13:0] instr,
  input  wire [12:0] pc_plus1,
  input  wire        call_push,
  input  wire [7:0]  file_rdata,
  output reg  [6:0]  file_addr,
  output reg  [7:0]  file_wdata,
  output reg         file_we,
  output reg  [12:0] pc,
  output reg         pc_load,
  output reg  [7:0]  w_reg,
  output reg         carry,
  output reg  [7:0]  irq_control_reg,
  output reg         busy,
  output reg         no_operation_instr
);
  // ==========================================
  // Reset release
  reg rst_meta;
  reg rst_n;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end
  // ==========================================
  // Decode
  wire take                  = instr_valid & ~busy;
  wire is_no_op              = (instr & `NO_OP_MASK) == `NO_OP_PAT;
  wire interrupt_exit_instr  = instr == `IRQ_EXIT_PAT;
  wire sub_exit_instr        = instr == `SUB_EXIT_PAT;
  wire literal_exit_instr    = (instr & `LIT_MASK) == `LIT_PAT;
  wire rotate_left_carry_instr = (instr & `ROT_MASK) == `ROT_PAT;
  wire any_exit = interrupt_exit_instr | sub_exit_instr | literal_exit_instr;
  wire do_pop   = take & any_exit;
  wire take_no_op  = take & is_no_op;
  wire take_rotate = take & rotate_left_carry_instr;
  // ==========================================
  // Return stack
  wire [12:0] stack_top_entry;
  ret_stack #(
    .DEPTH (STACK_DEPTH),
    .AW    (STACK_AW),
    .WIDTH (13)
  ) u_stack (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (call_push & ~do_pop),
    .push_data (pc_plus1),
    .pop       (do_pop),
    .top       (stack_top_entry)
  );
  // ==========================================
  // Rotate: file data is combinational from the addressed register
  // Address is registered from the instruction field, so it reaches the file one cycle after the issue cycle
  wire [7:0] rot_result = {file_rdata[6:0], carry};
  // ==========================================
  // Two-cycle sequencing of returns
  // The stack read is registered, so a return needs a second cycle before
  // the popped address is ready; busy holds the fetch unit off meanwhile.
  localparam ST_IDLE = 1'b0;
  localparam ST_LOAD = 1'b1;
  reg        state;
  reg        next_state;
  reg        next_busy;
  always @* begin
    next_state = state;
    next_busy  = busy;
    case (state)
      ST_IDLE: begin
        if (do_pop) begin
          next_state = ST_LOAD;
          next_busy  = 1'b1;
        end
      end
      ST_LOAD: begin
        next_state = ST_IDLE;
        next_busy  = 1'b0;
      end
      default: begin
        next_state = ST_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      busy  <= 1'b0;
    end else begin
      state <= next_state;
      busy  <= next_busy;
    end
  end
  // ==========================================
  // Program counter: loaded from the popped entry in the second cycle
  reg [12:0] next_pc;
  reg        next_pc_load;
  always @* begin
    next_pc      = pc;
    next_pc_load = 1'b0;
    if (state == ST_LOAD) begin
      next_pc      = stack_top_entry;
      next_pc_load = 1'b1;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc      <= `PC_RESET;
      pc_load <= 1'b0;
    end else begin
      pc      <= next_pc;
      pc_load <= next_pc_load;
    end
  end
  // ==========================================
  // Accumulator: literal of a literal exit, or a rotate with d=0
  reg [7:0]  next_w_reg;
  always @* begin
    next_w_reg = w_reg;
    if (take & literal_exit_instr) begin
      next_w_reg = instr[7:0];
    end else if (take_rotate & ~instr[`DEST_BIT]) begin
      next_w_reg = rot_result;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_reg <= `W_RESET;
    end else begin
      w_reg <= next_w_reg;
    end
  end
  // ==========================================
  // Carry: only a rotate touches it; returns and no-ops leave it alone
  reg        next_carry;
  always @* begin
    next_carry = carry;
    if (take_rotate) begin
      next_carry = file_rdata[7];
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry <= 1'b0;
    end else begin
      carry <= next_carry;
    end
  end
  // ==========================================
  // Interrupt control: only the enable bit is ever written here
  reg [7:0]  next_irq_control_reg;
  always @* begin
    next_irq_control_reg = irq_control_reg;
    if (take & interrupt_exit_instr) begin
      next_irq_control_reg[`IRQ_ENABLE_BIT] = 1'b1;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_control_reg <= `ICR_RESET;
    end else begin
      irq_control_reg <= next_irq_control_reg;
    end
  end
  // ==========================================
  // File write-back of a rotate with d=1
  reg [6:0]  next_file_addr;
  reg [7:0]  next_file_wdata;
  reg        next_file_we;
  always @* begin
    next_file_addr  = instr[6:0];
    next_file_wdata = file_wdata;
    next_file_we    = 1'b0;
    if (take_rotate & instr[`DEST_BIT]) begin
      next_file_wdata = rot_result;
      next_file_we    = 1'b1;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_addr  <= 7'h00;
      file_wdata <= 8'h00;
      file_we    <= 1'b0;
    end else begin
      file_addr  <= next_file_addr;
      file_wdata <= next_file_wdata;
      file_we    <= next_file_we;
    end
  end
  // ==========================================
  // No-operation: a one-cycle pulse and nothing else
  reg        next_no_op;
  always @* begin
    next_no_op = take_no_op;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      no_operation_instr <= 1'b0;
    end else begin
      no_operation_instr <= next_no_op;
    end
  end
endmodule // return_rotate_nop_exec
`default_nettype wire

// *** rret_consts.vh ***
// Constants for the return/rotate/no-operation execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
`ifndef RRET_CONSTS_VH
`define RRET_CONSTS_VH
// ==========================================
// Opcode patterns and masks
`define NO_OP_MASK   14'h3F9F
`define NO_OP_PAT    14'h0000
`define IRQ_EXIT_PAT 14'h0009
`define SUB_EXIT_PAT 14'h0008
`define LIT_MASK     14'h3C00
`define LIT_PAT      14'h3400
`define ROT_MASK     14'h3F00
`define ROT_PAT      14'h0D00
// ==========================================
// Field positions
`define DEST_BIT     7
`define IRQ_ENABLE_BIT 7
// ==========================================
// Reset values and timing
`define PC_RESET     13'h0000
`define W_RESET      8'h00
`define ICR_RESET    8'h00
`define RET_CYCLES   2
`endif

// *** ret_stack.v ***
// Hardware return stack with a registered top-of-stack output.
// Assumes push and pop are never asserted together.
`timescale 1ns/1ps
`default_nettype none
module ret_stack #(
  parameter DEPTH = 8,
  parameter AW    = 3,
  parameter WIDTH = 13
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  input  wire             pop,
  output reg  [WIDTH-1:0] top
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    sp;
  // ==========================================
  // Pointer: a pop steps back one entry
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= {AW{1'b0}};
    end else if (push) begin
      sp <= sp + 1'b1;
    end else if (pop) begin
      sp <= sp - 1'b1;
    end
  end
  always @(posedge clk) begin
    if (push) begin
      mem[sp] <= push_data;
    end
  end
  // Registered read of the entry being popped
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      top <= {WIDTH{1'b0}};
    end else if (pop) begin
      top <= mem[sp - 1'b1];
    end
  end
endmodule // ret_stack
`default_nettype wire

// *** return_rotate_nop_exec_checker.sv ***
// Port checker for the return, rotate and no-operation block.
// Assumes rret_consts.vh is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "rret_consts.vh"
module rrne_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        instr_valid,
  input wire logic [13:0] instr,
  input wire logic [7:0]  file_rdata,
  input wire logic [6:0]  file_addr,
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  input wire logic        pc_load,
  input wire logic [7:0]  w_reg,
  input wire logic        carry,
  input wire logic [7:0]  irq_control_reg,
  input wire logic        busy,
  input wire logic        no_operation_instr
);
  // ====================
  // Taken requests
  wire tk  = instr_valid && !busy;
  wire rot = tk && ((instr & `ROT_MASK) == `ROT_PAT);
  wire lit = tk && ((instr & `LIT_MASK) == `LIT_PAT);
  wire irq = tk && (instr == `IRQ_EXIT_PAT);
  wire ret = lit || irq || (tk && instr == `SUB_EXIT_PAT);
  wire idle = tk && ((instr & `NO_OP_MASK) == `NO_OP_PAT);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  rot_carry_a: assert property (rot |=> carry == $past(file_rdata[7]))
    else $error("rotate carry wrong");
  rot_w_a: assert property (rot && !instr[7] |=> !file_we &&
    w_reg == {$past(file_rdata[6:0]), $past(carry)}) else $error("rotate to w wrong");
  rot_f_a: assert property (rot && instr[7] |=> file_we && $stable(w_reg) &&
    file_addr == $past(instr[6:0]) && file_wdata == {$past(file_rdata[6:0]), $past(carry)})
    else $error("rotate to f wrong");
  lit_w_a: assert property (lit |=> w_reg == $past(instr[7:0]))
    else $error("literal not in w");
  ret_time_a: assert property (ret |=> busy ##1 (pc_load && !busy))
    else $error("return timing wrong");
  ret_flag_a: assert property (ret |=> $stable(carry) [*2])
    else $error("return changed carry");
  irq_enable_a: assert property (irq |=> irq_control_reg[7])
    else $error("enable bit not set");
  no_change_a: assert property (idle |=> no_operation_instr && !file_we && !pc_load &&
    $stable(w_reg) && $stable(carry)) else $error("no-op changed state");
  busy_refuse_a: assert property (instr_valid && busy |=> !file_we && !no_operation_instr)
    else $error("request taken while busy");
  cover property (rot && instr[7]);
  cover property (irq);
  cover property (idle);
  cover property (lit ##1 instr_valid && busy);
endmodule // rrne_checker
bind return_rotate_nop_exec rrne_checker u_chk (.clk, .resetn, .instr_valid, .instr,
  .file_rdata, .file_addr, .file_wdata, .file_we, .pc_load, .w_reg, .carry,
  .irq_control_reg, .busy, .no_operation_instr);
`default_nettype wire

// *** return_rotate_nop_exec_tb.sv ***
// Self-checking bench for the return, rotate and no-operation block.
// Assumes the design and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module return_rotate_nop_exec_tb;
  logic        clk = 0, resetn = 0, instr_valid = 0, call_push = 0;
  logic [13:0] instr = 14'h0000;
  logic [12:0] pc_plus1 = 13'h0000;
  logic [7:0]  file_rdata = 8'he6;
  wire  [6:0]  file_addr;
  wire  [7:0]  file_wdata, w_reg, irq_control_reg;
  wire  [12:0] pc;
  wire         file_we, pc_load, carry, busy, no_operation_instr;
  int          mismatches = 0, checks_done = 0;
  return_rotate_nop_exec u_dut (.clk, .resetn, .instr_valid, .instr, .pc_plus1, .call_push,
    .file_rdata, .file_addr, .file_wdata, .file_we, .pc, .pc_load, .w_reg, .carry,
    .irq_control_reg, .busy, .no_operation_instr);
  initial forever #20 clk = ~clk;
  // ====================
  // Shared tasks
  task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic issue(logic [13:0] v);
    @(posedge clk);
    instr <= v;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic push(logic [12:0] a);
    @(posedge clk);
    call_push <= 1'b1;
    pc_plus1 <= a;
    @(posedge clk);
    call_push <= 1'b0;
  endtask
  task automatic ret_pc(logic [12:0] a);
    chk("busy", 1, busy);
    @(posedge clk);
    #1;
    chk("pc_load", 1, pc_load);
    chk("pc", a, pc);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic t_rotate;
    issue(14'h0d85);
    chk("wdata", 8'hcc, file_wdata);
    chk("we", 1, file_we);
    chk("addr", 7'h05, file_addr);
    chk("carry", 1, carry);
    issue(14'h0d05);
    chk("w", 8'hcd, w_reg);
    chk("we", 0, file_we);
    @(posedge clk);
    file_rdata <= 8'h71;
    issue(14'h0d7f);
    chk("w", 8'he3, w_reg);
    chk("carry", 0, carry);
  endtask
  task automatic t_nop;
    issue(14'h0060);
    chk("no_op", 1, no_operation_instr);
    chk("w", 8'he3, w_reg);
    chk("carry", 0, carry);
    @(posedge clk);
    #1;
    chk("no_op", 0, no_operation_instr);
  endtask
  task automatic t_returns;
    push(13'h0123);
    push(13'h0456);
    push(13'h1abc);
    issue(14'h37ab);
    chk("w", 8'hab, w_reg);
    ret_pc(13'h1abc);
    issue(14'h0009);
    chk("irq_en", 1, irq_control_reg[7]);
    ret_pc(13'h0456);
    issue(14'h0008);
    ret_pc(13'h0123);
    chk("carry", 0, carry);
  endtask
  task automatic t_reset;
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    #1;
    chk("pc", 13'h0000, pc);
    chk("w", 8'h00, w_reg);
    chk("irq_en", 0, irq_control_reg[7]);
    chk("busy", 0, busy);
    @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    issue(14'h0d05);
    chk("w", 8'he2, w_reg);
    chk("carry", 0, carry);
  endtask
  task automatic t_refuse;
    push(13'h0777);
    @(posedge clk);
    instr <= 14'h0008;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr <= 14'h0d85;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("pc", 13'h0777, pc);
    chk("we", 0, file_we);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_rotate();
    t_nop();
    t_returns();
    t_refuse();
    t_reset();
    complete_run();
  end
  initial begin
    #80000;
    mismatches++;
    complete_run();
  end
endmodule // return_rotate_nop_exec_tb
`default_nettype wire
